// >>> design/brc_map.vh
// Behaviour
// - bit 16 clear ignores secondary parity errors, set enables detection; resets zero
// - forward mode: bit 16 governs response to secondary address, attribute, data errors
// - reverse mode: bit 16 lets poisoned TLP set master data parity error status
// - bit 17 forward: secondary system error becomes error message; reverse read-only
// - bit 18 clear: forward downstream all I/O inside base/limit window; resets zero
// - bit 18 set: window I/O in first 64KB, upper 768 bytes per 1KB goes upstream
// - bit 19 set: forward VGA memory and I/O when enables set, ignoring ISA bit
// - bit 19 clear: VGA accesses forwarded only through programmed forwarding ranges
// - bit 20 selects VGA I/O decode: clear 10 address bits, set 16 bits
// - bit 21 clear: master aborts silent, reads give all ones, writes dropped
// - bit 21 set: report master abort by target abort, else system error if enabled
// - bit 22 holds secondary bus reset forward, or hot reset reverse; resets zero
// - bit 23 read-only zero, fast back-to-back unsupported
// - bit 24 primary discard length 2^15 or 2^10 clocks; read-only in forward
// - bit 25 secondary discard length 2^15 or 2^10 clocks; read-only in reverse
// - bit 26 set on discard expiry dropping delayed completion; write one clears
// - bit 27 set: expiry sends error message forward, primary system error reverse
`ifndef BRC_MAP_VH
`define BRC_MAP_VH
// register byte addresses
`define BRC_ADDR_BRIDGE_CONTROL 8'h3c
`define BRC_ADDR_IRQ_STATUS     8'h80
`define BRC_ADDR_IRQ_ENABLE     8'h84
`define BRC_ADDR_IRQ_CLEAR      8'h88
// register select codes
`define BRC_SEL_NONE 2'h0
`define BRC_SEL_CTL  2'h1
`define BRC_SEL_STAT 2'h2
`define BRC_SEL_ENA  2'h3
// bridge control field positions in the 32-bit word
`define BRC_B_PERR   16
`define BRC_B_SERR   17
`define BRC_B_ISA    18
`define BRC_B_VGA    19
`define BRC_B_VGA16  20
`define BRC_B_MABORT 21
`define BRC_B_SECRST 22
`define BRC_B_FB2B   23
`define BRC_B_PTMO   24
`define BRC_B_STMO   25
`define BRC_B_TMOST  26
`define BRC_B_TMOSE  27
// interrupt status bit positions
`define BRC_I_DISCARD 0
`define BRC_I_MABORT  1
`define BRC_I_SECSERR 2
`define BRC_I_PARITY  3
`define BRC_IRQ_W     4
// discard timer lengths in PCI clocks
`define BRC_DISCARD_LONG  16'h8000
`define BRC_DISCARD_SHORT 16'h0400
// I/O and VGA decode constants
`define BRC_ISA_TOP      32'h0001_0000
`define BRC_VGA_MEM_LO   32'h000a_0000
`define BRC_VGA_MEM_HI   32'h000b_ffff
`define BRC_VGA_IO_A_LO  10'h3b0
`define BRC_VGA_IO_A_HI  10'h3bb
`define BRC_VGA_IO_B_LO  10'h3c0
`define BRC_VGA_IO_B_HI  10'h3df
`define BRC_ALL_ONES     32'hffff_ffff
`define BRC_RESP_OKAY    2'h0
`define BRC_RESP_SLVERR  2'h2
`endif

// >>> design/brc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "brc_map.vh"
module brc_top (
  input  wire        CLOCK_I,
  input  wire        RST_I,
  // axi4-lite slave
  input  wire [7:0]  S_AXI_AWADDR_I,
  input  wire        S_AXI_AWVALID_I,
  output reg         S_AXI_AWREADY_O,
  input  wire [31:0] S_AXI_WDATA_I,
  input  wire [3:0]  S_AXI_WSTRB_I,
  input  wire        S_AXI_WVALID_I,
  output reg         S_AXI_WREADY_O,
  output reg  [1:0]  S_AXI_BRESP_O,
  output reg         S_AXI_BVALID_O,
  input  wire        S_AXI_BREADY_I,
  input  wire [7:0]  S_AXI_ARADDR_I,
  input  wire        S_AXI_ARVALID_I,
  output reg         S_AXI_ARREADY_O,
  output reg  [31:0] S_AXI_RDATA_O,
  output reg  [1:0]  S_AXI_RRESP_O,
  output reg         S_AXI_RVALID_O,
  input  wire        S_AXI_RREADY_I,
  // bridge direction: 0 forward, 1 reverse
  input  wire        REVERSE_MODE_I,
  // events from the bridge datapath
  input  wire        SEC_PARITY_ERR_I,
  input  wire        SEC_SYSTEM_ERR_I,
  input  wire        MASTER_ABORT_I,
  input  wire        TARGET_ABORT_OK_I,
  input  wire        SERR_ENABLE_I,
  input  wire        DISCARD_DROP_I,
  // access under decode
  input  wire [31:0] ACC_ADDR_I,
  input  wire        ACC_IS_IO_I,
  input  wire [31:0] IO_BASE_I,
  input  wire [31:0] IO_LIMIT_I,
  input  wire        IO_ENABLE_I,
  input  wire        MEM_ENABLE_I,
  input  wire        MEM_IN_RANGE_I,
  // results
  output reg         IO_FWD_DOWN_O,
  output reg         IO_FWD_UP_O,
  output reg         VGA_FWD_O,
  output reg         MEM_FWD_O,
  output reg  [31:0] MA_READ_DATA_O,
  output reg         MA_TARGET_ABORT_O,
  output reg         SYSTEM_ERROR_N_O,
  output reg         PRIMARY_SYSTEM_ERROR_N_O,
  output reg         ERR_MESSAGE_O,
  output reg         SEC_ERR_RESPOND_O,
  output reg         MDPE_SET_O,
  output reg         SEC_BUS_RESET_N_O,
  output reg         HOT_RESET_O,
  output reg  [15:0] PRI_DISCARD_CYCLES_O,
  output reg  [15:0] SEC_DISCARD_CYCLES_O,
  output reg         IRQ_O
);

  // address to register select, shared by read and write paths
  function [1:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `BRC_ADDR_BRIDGE_CONTROL: reg_sel = `BRC_SEL_CTL;
        `BRC_ADDR_IRQ_STATUS:     reg_sel = `BRC_SEL_STAT;
        `BRC_ADDR_IRQ_ENABLE:     reg_sel = `BRC_SEL_ENA;
        default:                  reg_sel = `BRC_SEL_NONE;
      endcase
    end
  endfunction

  // bridge control fields, interrupt status and enable, registered direction
  reg                  perr_en;
  reg                  serr_fwd;
  reg                  isa_en;
  reg                  vga_en;
  reg                  vga16;
  reg                  mabort_mode;
  reg                  sec_reset;
  reg                  pri_short;
  reg                  sec_short;
  reg                  tmo_status;
  reg                  tmo_serr;
  reg [`BRC_IRQ_W-1:0] irq_status;
  reg [`BRC_IRQ_W-1:0] irq_enable;
  reg                  reverse;
  // held write request
  reg [7:0]            aw_addr;
  reg [31:0]           w_data;
  reg [3:0]            w_strb;

  wire        fwd      = ~reverse;
  wire        do_write = ~S_AXI_AWREADY_O & ~S_AXI_WREADY_O & ~S_AXI_BVALID_O;
  wire [1:0]  wsel     = reg_sel(aw_addr);
  wire        ctl_hi   = do_write & (wsel == `BRC_SEL_CTL) & w_strb[3];
  wire        ctl_lo   = do_write & (wsel == `BRC_SEL_CTL) & w_strb[2];
  wire        clr_wr   = do_write & (aw_addr == `BRC_ADDR_IRQ_CLEAR) & w_strb[0];
  wire        known_w  = (wsel != `BRC_SEL_NONE) | (aw_addr == `BRC_ADDR_IRQ_CLEAR);

  // control word as software reads it; unused low half and reserved bits read zero
  wire [31:0] ctl_word = {4'h0,
                          tmo_serr, tmo_status, sec_short, pri_short,
                          1'b0,
                          sec_reset, mabort_mode, vga16, vga_en,
                          isa_en, serr_fwd, perr_en, 16'h0000};

  // direction strap is taken by a clocked process so reset only loads a constant
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      reverse <= 1'b0;
    end else begin
      reverse <= REVERSE_MODE_I;
    end
  end

  // write channel: address and data taken in either order, response after both
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O  <= 1'b1;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= `BRC_RESP_OKAY;
      aw_addr         <= 8'h00;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_addr         <= S_AXI_AWADDR_I;
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_data         <= S_AXI_WDATA_I;
        w_strb         <= S_AXI_WSTRB_I;
        S_AXI_WREADY_O <= 1'b0;
      end
      if (do_write) begin
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= known_w ? `BRC_RESP_OKAY : `BRC_RESP_SLVERR;
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O  <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O  <= 1'b1;
      end
    end
  end

  // read channel: one cycle from address to data
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h0000_0000;
      S_AXI_RRESP_O   <= `BRC_RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
        S_AXI_ARREADY_O <= 1'b0;
        S_AXI_RVALID_O  <= 1'b1;
        S_AXI_RRESP_O   <= `BRC_RESP_OKAY;
        case (reg_sel(S_AXI_ARADDR_I))
          `BRC_SEL_CTL:  S_AXI_RDATA_O <= ctl_word;
          `BRC_SEL_STAT: S_AXI_RDATA_O <= {{(32-`BRC_IRQ_W){1'b0}}, irq_status};
          `BRC_SEL_ENA:  S_AXI_RDATA_O <= {{(32-`BRC_IRQ_W){1'b0}}, irq_enable};
          default: begin
            // the clear register is write-only and reads zero without error
            S_AXI_RDATA_O <= 32'h0000_0000;
            if (S_AXI_ARADDR_I != `BRC_ADDR_IRQ_CLEAR) begin
              S_AXI_RRESP_O <= `BRC_RESP_SLVERR;
            end
          end
        endcase
      end
      if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O  <= 1'b0;
        S_AXI_ARREADY_O <= 1'b1;
      end
    end
  end

  // control field writes; direction-dependent bits stay read-only in the other mode
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      perr_en     <= 1'b0;
      serr_fwd    <= 1'b0;
      isa_en      <= 1'b0;
      vga_en      <= 1'b0;
      vga16       <= 1'b0;
      mabort_mode <= 1'b0;
      sec_reset   <= 1'b0;
      pri_short   <= 1'b0;
      sec_short   <= 1'b0;
      tmo_serr    <= 1'b0;
    end else begin
      if (ctl_lo) begin
        perr_en     <= w_data[`BRC_B_PERR];
        if (fwd) begin
          serr_fwd  <= w_data[`BRC_B_SERR];
        end
        isa_en      <= w_data[`BRC_B_ISA];
        vga_en      <= w_data[`BRC_B_VGA];
        vga16       <= w_data[`BRC_B_VGA16];
        mabort_mode <= w_data[`BRC_B_MABORT];
        sec_reset   <= w_data[`BRC_B_SECRST];
      end
      if (ctl_hi) begin
        if (reverse) begin
          pri_short <= w_data[`BRC_B_PTMO];
        end
        if (fwd) begin
          sec_short <= w_data[`BRC_B_STMO];
        end
        tmo_serr    <= w_data[`BRC_B_TMOSE];
      end
    end
  end

  // sticky flags: a new event in the clearing cycle wins over the clear
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      tmo_status <= 1'b0;
      irq_status <= {`BRC_IRQ_W{1'b0}};
      irq_enable <= {`BRC_IRQ_W{1'b0}};
      IRQ_O      <= 1'b0;
    end else begin
      tmo_status <= (tmo_status & ~(ctl_hi & w_data[`BRC_B_TMOST])) | DISCARD_DROP_I;
      irq_status <= (irq_status & ~({`BRC_IRQ_W{clr_wr}} & w_data[`BRC_IRQ_W-1:0]))
                  | {SEC_PARITY_ERR_I & perr_en, SEC_SYSTEM_ERR_I,
                     MASTER_ABORT_I, DISCARD_DROP_I};
      if (do_write && wsel == `BRC_SEL_ENA && w_strb[0]) begin
        irq_enable <= w_data[`BRC_IRQ_W-1:0];
      end
      // level output, one cycle behind the status it reflects
      IRQ_O <= |(irq_status & irq_enable);
    end
  end

  // address decode for I/O, VGA and memory forwarding
  wire        io_in_win = ACC_IS_IO_I & (ACC_ADDR_I >= IO_BASE_I) & (ACC_ADDR_I <= IO_LIMIT_I);
  wire        isa_hit   = (ACC_ADDR_I < `BRC_ISA_TOP) & (ACC_ADDR_I[9:8] != 2'b00);
  wire [9:0]  io_low    = ACC_ADDR_I[9:0];
  // 10-bit decode aliases the VGA ports across the space; 16-bit needs bits 15:10 zero
  wire        vga_io    = ((io_low >= `BRC_VGA_IO_A_LO) & (io_low <= `BRC_VGA_IO_A_HI)
                         | (io_low >= `BRC_VGA_IO_B_LO) & (io_low <= `BRC_VGA_IO_B_HI))
                         & (~vga16 | (ACC_ADDR_I[15:10] == 6'h00));
  wire        vga_mem   = (ACC_ADDR_I >= `BRC_VGA_MEM_LO) & (ACC_ADDR_I <= `BRC_VGA_MEM_HI);

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      IO_FWD_DOWN_O <= 1'b0;
      IO_FWD_UP_O   <= 1'b0;
      VGA_FWD_O     <= 1'b0;
      MEM_FWD_O     <= 1'b0;
    end else begin
      IO_FWD_UP_O   <= IO_ENABLE_I & io_in_win & isa_en & isa_hit;
      IO_FWD_DOWN_O <= IO_ENABLE_I & io_in_win & ~(isa_en & isa_hit);
      // vga path is independent of the isa bit
      VGA_FWD_O     <= vga_en & ((ACC_IS_IO_I & IO_ENABLE_I & vga_io)
                     | (~ACC_IS_IO_I & MEM_ENABLE_I & vga_mem));
      // with vga off, legacy addresses go only through the programmed ranges
      MEM_FWD_O     <= ~ACC_IS_IO_I & MEM_ENABLE_I & MEM_IN_RANGE_I;
    end
  end

  // error reporting, secondary reset and discard lengths
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      MA_READ_DATA_O           <= 32'h0000_0000;
      MA_TARGET_ABORT_O        <= 1'b0;
      SYSTEM_ERROR_N_O         <= 1'b1;
      PRIMARY_SYSTEM_ERROR_N_O <= 1'b1;
      ERR_MESSAGE_O            <= 1'b0;
      SEC_ERR_RESPOND_O        <= 1'b0;
      MDPE_SET_O               <= 1'b0;
      SEC_BUS_RESET_N_O        <= 1'b1;
      HOT_RESET_O              <= 1'b0;
      PRI_DISCARD_CYCLES_O     <= `BRC_DISCARD_LONG;
      SEC_DISCARD_CYCLES_O     <= `BRC_DISCARD_LONG;
    end else begin
      // silent abort returns all ones; reporting mode passes no substitute data
      MA_READ_DATA_O    <= mabort_mode ? 32'h0000_0000 : `BRC_ALL_ONES;
      MA_TARGET_ABORT_O <= MASTER_ABORT_I & mabort_mode & TARGET_ABORT_OK_I;
      SYSTEM_ERROR_N_O  <= ~(MASTER_ABORT_I & mabort_mode
                           & ~TARGET_ABORT_OK_I & SERR_ENABLE_I);
      PRIMARY_SYSTEM_ERROR_N_O <= ~(DISCARD_DROP_I & tmo_serr & reverse);
      ERR_MESSAGE_O     <= fwd & ((SEC_SYSTEM_ERR_I & serr_fwd)
                         | (DISCARD_DROP_I & tmo_serr));
      SEC_ERR_RESPOND_O <= fwd & perr_en & SEC_PARITY_ERR_I;
      MDPE_SET_O        <= reverse & perr_en & SEC_PARITY_ERR_I;
      SEC_BUS_RESET_N_O <= ~(sec_reset & fwd);
      HOT_RESET_O       <= sec_reset & reverse;
      // the length bit is ignored in the mode where it is read-only
      PRI_DISCARD_CYCLES_O <= (reverse & pri_short) ? `BRC_DISCARD_SHORT
                                                    : `BRC_DISCARD_LONG;
      SEC_DISCARD_CYCLES_O <= (fwd & sec_short) ? `BRC_DISCARD_SHORT
                                                : `BRC_DISCARD_LONG;
    end
  end

endmodule // brc_top
`default_nettype wire

// >>> tb/brc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// port-level watch on the control block; sees only top ports
module brc_top_sva (
  input wire logic        CLOCK_I, RST_I, S_AXI_AWVALID_I, S_AXI_AWREADY_O,
  input wire logic        S_AXI_WVALID_I, S_AXI_WREADY_O, S_AXI_BVALID_O,
  input wire logic        S_AXI_ARVALID_I, S_AXI_ARREADY_O, S_AXI_RVALID_O,
  input wire logic        MASTER_ABORT_I, TARGET_ABORT_OK_I, SERR_ENABLE_I,
  input wire logic        DISCARD_DROP_I, SEC_PARITY_ERR_I, SEC_SYSTEM_ERR_I,
  input wire logic        MA_TARGET_ABORT_O, SYSTEM_ERROR_N_O, PRIMARY_SYSTEM_ERROR_N_O,
  input wire logic        ERR_MESSAGE_O, SEC_ERR_RESPOND_O, MDPE_SET_O,
  input wire logic        SEC_BUS_RESET_N_O, HOT_RESET_O, IO_FWD_UP_O,
  input wire logic        IO_FWD_DOWN_O, ACC_IS_IO_I,
  input wire logic [31:0] ACC_ADDR_I,
  input wire logic [15:0] PRI_DISCARD_CYCLES_O, SEC_DISCARD_CYCLES_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  // bus timing: write answers two edges after both channels are taken
  a_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
    && S_AXI_WREADY_O |=> !S_AXI_BVALID_O ##1 S_AXI_BVALID_O) else $error("write answer late");
  a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O
    && !S_AXI_ARREADY_O) else $error("read answer late");
  // every error output must trace back to its event one edge earlier
  a_abort_target: assert property (MA_TARGET_ABORT_O |-> $past(MASTER_ABORT_I)
    && $past(TARGET_ABORT_OK_I)) else $error("target abort without cause");
  a_abort_serr: assert property (!SYSTEM_ERROR_N_O |-> $past(MASTER_ABORT_I)
    && $past(SERR_ENABLE_I) && !$past(TARGET_ABORT_OK_I)) else $error("system error wrong");
  a_discard_serr: assert property (!PRIMARY_SYSTEM_ERROR_N_O |-> $past(DISCARD_DROP_I))
    else $error("primary system error without drop");
  a_err_msg_cause: assert property (ERR_MESSAGE_O |-> $past(SEC_SYSTEM_ERR_I)
    || $past(DISCARD_DROP_I)) else $error("error message without cause");
  a_poison_mdpe: assert property (MDPE_SET_O |-> $past(SEC_PARITY_ERR_I))
    else $error("parity status without poison");
  a_parity_respond: assert property (SEC_ERR_RESPOND_O |-> $past(SEC_PARITY_ERR_I)
    && !MDPE_SET_O) else $error("parity response wrong");
  // isa aliasing only sends the upper 768 bytes of each 1KB below 64KB upstream
  a_isa_upstream: assert property (IO_FWD_UP_O |-> !IO_FWD_DOWN_O && $past(ACC_IS_IO_I)
    && ($past(ACC_ADDR_I) & 32'hffff_0000) == 32'h0
    && ($past(ACC_ADDR_I) & 32'h0000_0300) != 32'h0) else $error("bad upstream i/o");
  a_reset_one_mode: assert property (!(!SEC_BUS_RESET_N_O && HOT_RESET_O))
    else $error("both secondary resets active");
  a_discard_length: assert property ((PRI_DISCARD_CYCLES_O == 16'h8000
    || PRI_DISCARD_CYCLES_O == 16'h0400) && (SEC_DISCARD_CYCLES_O == 16'h8000
    || SEC_DISCARD_CYCLES_O == 16'h0400)) else $error("bad discard length");
endmodule // brc_top_sva

bind brc_top brc_top_sva u_sva (.*);
`default_nettype wire

// >>> tb/brc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module brc_top_tb;
  logic        CLOCK_I, RST_I, S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I;
  logic        S_AXI_ARVALID_I, S_AXI_RREADY_I, REVERSE_MODE_I, TARGET_ABORT_OK_I;
  logic        SERR_ENABLE_I, SEC_PARITY_ERR_I, SEC_SYSTEM_ERR_I, MASTER_ABORT_I;
  logic        DISCARD_DROP_I, ACC_IS_IO_I, MEM_IN_RANGE_I;
  logic [7:0]  S_AXI_AWADDR_I, S_AXI_ARADDR_I;
  logic [3:0]  S_AXI_WSTRB_I;
  logic [31:0] S_AXI_WDATA_I, ACC_ADDR_I;
  wire         S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
  wire         S_AXI_RVALID_O, IO_FWD_DOWN_O, IO_FWD_UP_O, VGA_FWD_O, MEM_FWD_O;
  wire         MA_TARGET_ABORT_O, SYSTEM_ERROR_N_O, PRIMARY_SYSTEM_ERROR_N_O, ERR_MESSAGE_O;
  wire         SEC_ERR_RESPOND_O, MDPE_SET_O, SEC_BUS_RESET_N_O, HOT_RESET_O, IRQ_O;
  wire [1:0]   S_AXI_BRESP_O, S_AXI_RRESP_O;
  wire [31:0]  S_AXI_RDATA_O, MA_READ_DATA_O;
  wire [15:0]  PRI_DISCARD_CYCLES_O, SEC_DISCARD_CYCLES_O;
  wire [3:0]   fwd = {IO_FWD_UP_O, IO_FWD_DOWN_O, VGA_FWD_O, MEM_FWD_O};
  int          failures = 0;
  int          compares = 0;

  // window spans the first 64KB; memory range hit is driven so plain range forwarding is seen
  brc_top dut (.IO_BASE_I(32'h0), .IO_LIMIT_I(32'h0000_ffff), .IO_ENABLE_I(1'b1),
    .MEM_ENABLE_I(1'b1), .*);

  // 25 MHz clock
  initial begin
    CLOCK_I = 1'b0;
    forever #20 CLOCK_I = ~CLOCK_I;
  end

  function automatic logic [1:0] resp_for(input logic [7:0] a);
    resp_for = (a == 8'h3c || a == 8'h80 || a == 8'h84 || a == 8'h88) ? 2'h0 : 2'h2;
  endfunction

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // each channel drops valid on its own ready; the #1 lets the last edge settle
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK_I);
    {S_AXI_AWADDR_I, S_AXI_WDATA_I} <= {a, d};
    {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} <= 3'h7;
    do begin
      @(posedge CLOCK_I);
      if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
      if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
    end while (!S_AXI_BVALID_O);
    S_AXI_BREADY_I <= 1'b0;
    chk("bresp", S_AXI_BRESP_O, resp_for(a));
    #1;
  endtask

  task automatic r(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLOCK_I);
    S_AXI_ARADDR_I <= a;
    {S_AXI_ARVALID_I, S_AXI_RREADY_I} <= 2'h3;
    do begin
      @(posedge CLOCK_I);
      if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
    end while (!S_AXI_RVALID_O);
    S_AXI_RREADY_I <= 1'b0;
    chk("rdata", S_AXI_RDATA_O, e);
    chk("rresp", S_AXI_RRESP_O, resp_for(a));
    #1;
  endtask

  // one-cycle event pulses; outputs are registered once, so look just after the next edge
  task automatic fire(input logic [3:0] v);
    @(posedge CLOCK_I);
    {DISCARD_DROP_I, MASTER_ABORT_I, SEC_SYSTEM_ERR_I, SEC_PARITY_ERR_I} <= v;
    @(posedge CLOCK_I);
    {DISCARD_DROP_I, MASTER_ABORT_I, SEC_SYSTEM_ERR_I, SEC_PARITY_ERR_I} <= 4'h0;
    #1;
  endtask

  task automatic dec(input logic [31:0] a, input logic io, input int i, input logic e);
    @(posedge CLOCK_I);
    {ACC_ADDR_I, ACC_IS_IO_I} <= {a, io};
    repeat (2) @(posedge CLOCK_I);
    #1 chk("forward decode", fwd[i], e);
  endtask

  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // the full sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge CLOCK_I);
    failures++;
    end_of_test();
  end

  // main sequence
  initial begin
    RST_I <= 1'b1;
    {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_RREADY_I} <= '0;
    {REVERSE_MODE_I, SEC_PARITY_ERR_I, SEC_SYSTEM_ERR_I, MASTER_ABORT_I, DISCARD_DROP_I} <= '0;
    {S_AXI_AWADDR_I, S_AXI_ARADDR_I, S_AXI_WDATA_I, ACC_ADDR_I, ACC_IS_IO_I} <= '0;
    MEM_IN_RANGE_I <= 1'b0;
    {TARGET_ABORT_OK_I, SERR_ENABLE_I, S_AXI_WSTRB_I} <= {2'h3, 4'hf};
    repeat (20) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    r(8'h3c, 32'h0);
    chk("abort data", MA_READ_DATA_O, 32'hffff_ffff);
    r(8'h40, 32'h0);
    w(8'h40, 32'hffff_ffff);
    w(8'h3c, 32'hffff_ffff);
    r(8'h3c, 32'h0a7f_0000);
    chk("resets", {SEC_BUS_RESET_N_O, HOT_RESET_O}, 32'h0);
    chk("discard", {PRI_DISCARD_CYCLES_O, SEC_DISCARD_CYCLES_O}, 32'h8000_0400);
    chk("abort data", MA_READ_DATA_O, 32'h0);
    w(8'h84, 32'hf);
    fire(4'h1);
    chk("parity respond", SEC_ERR_RESPOND_O, 1'b1);
    fire(4'h2);
    chk("err message", ERR_MESSAGE_O, 1'b1);
    fire(4'h4);
    chk("target abort", MA_TARGET_ABORT_O, 1'b1);
    fire(4'h8);
    chk("drop report", {ERR_MESSAGE_O, PRIMARY_SYSTEM_ERROR_N_O}, 32'h3);
    r(8'h80, 32'hf);
    chk("irq", IRQ_O, 1'b1);
    r(8'h3c, 32'h0e7f_0000);
    w(8'h3c, 32'h0e7f_0000);
    r(8'h3c, 32'h0a7f_0000);
    w(8'h88, 32'hf);
    r(8'h80, 32'h0);
    chk("irq", IRQ_O, 1'b0);
    w(8'h84, 32'h0);
    @(posedge CLOCK_I) TARGET_ABORT_OK_I <= 1'b0;
    fire(4'h4);
    chk("serr", SYSTEM_ERROR_N_O, 1'b0);
    r(8'h80, 32'h2);
    chk("masked irq", IRQ_O, 1'b0);
    w(8'h84, 32'h2);
    chk("irq", IRQ_O, 1'b1);
    w(8'h88, 32'h2);
    w(8'h3c, 32'h0);
    fire(4'hf);
    chk("quiet", {SEC_ERR_RESPOND_O, ERR_MESSAGE_O, SYSTEM_ERROR_N_O}, 32'h1);
    chk("abort data", MA_READ_DATA_O, 32'hffff_ffff);
    dec(32'h1100, 1'b1, 2, 1'b1);
    dec(32'h1100, 1'b1, 3, 1'b0);
    w(8'h3c, 32'h0004_0000);
    dec(32'h1100, 1'b1, 3, 1'b1);
    dec(32'h1000, 1'b1, 3, 1'b0);
    w(8'h3c, 32'h0008_0000);
    dec(32'h03c0, 1'b1, 1, 1'b1);
    dec(32'h000a_0000, 1'b0, 1, 1'b1);
    dec(32'h73c0, 1'b1, 1, 1'b1);
    w(8'h3c, 32'h0018_0000);
    dec(32'h73c0, 1'b1, 1, 1'b0);
    w(8'h3c, 32'h0);
    dec(32'h000a_0000, 1'b0, 1, 1'b0);
    dec(32'h000a_0000, 1'b0, 0, 1'b0);
    @(posedge CLOCK_I) MEM_IN_RANGE_I <= 1'b1;
    dec(32'h000a_0000, 1'b0, 0, 1'b1);
    @(posedge CLOCK_I) MEM_IN_RANGE_I <= 1'b0;
    @(posedge CLOCK_I) REVERSE_MODE_I <= 1'b1;
    w(8'h3c, 32'h0fff_0000);
    r(8'h3c, 32'h097d_0000);
    chk("resets", {SEC_BUS_RESET_N_O, HOT_RESET_O}, 32'h3);
    chk("pri discard", PRI_DISCARD_CYCLES_O, 16'h0400);
    fire(4'h9);
    chk("poison", {MDPE_SET_O, SEC_ERR_RESPOND_O, PRIMARY_SYSTEM_ERROR_N_O}, 32'h4);
    end_of_test();
  end
endmodule // brc_top_tb
`default_nettype wire
